// ==== verilog/xlat_regs.sv ====
/*
  stage 1 translation control and table base registers for three levels,
  reached over apb, plus a walk snapshot port for the table walker.
  assumes an apb master on pclk and a walker on the same clock that
  pulses walk_start for one cycle per walk.
*/
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps

// Contract
// - el1 bit 52 scopes lower tag ignore
// - el1 bit 51 scopes upper tag ignore
// - el1 bit 40 dirty update, needs bit 39
// - el1 bit 39 enables access flag update
// - el1 control fields reset unknown
// - el2/el3 bit 29 scopes tag ignore
// - el2/el3 bit 22 enables dirty update
// - el2/el3 bit 21 enables access flag update
// - host extension gives el2 the el1 layout
// - el3 control 32 bits, others 64
// - el1 base address_space_id bits 63:48, selectable
// - base address bits 47:1, low bits reserved
// - walks zero misaligned bits, reads keep them
// - base bit 0 is common-not-private
// - el1 bits 50:39 implemented, not reserved
module xlat_regs
  import xlat_regs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [STRB_W-1:0] pstrb,
  output logic                   pready,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pslverr,
  input  wire logic              walk_start,
  input  wire logic [1:0]        walk_regime,
  input  wire logic [5:0]        walk_align_lsb,
  output logic      [VA_W-1:0]   walk_table_base,
  output logic                   walk_common_not_private,
  output logic      [ADDRESS_SPACE_ID_W-1:0] walk_address_space_id,
  output logic                   walk_address_space_id_from_lower,
  output logic                   walk_lower_tag_scope,
  output logic                   walk_upper_tag_scope,
  output logic                   walk_access_flag_update,
  output logic                   walk_dirty_update,
  output logic                   walk_el1_layout
);

  // stored register images
  logic [63:0]        el1_ctrl_reg;   // full 64 bits incl. 50:39
  logic [63:0]        el2_ctrl_reg;
  logic [31:0]        el3_ctrl_reg;   // narrow register
  logic [63:0]        el1_base_reg;
  logic [63:0]        el2_base_reg;
  logic [63:0]        el3_base_reg;
  logic               host_ext_reg;   // el2 uses el1 layout
  logic [COUNT_W-1:0] walk_count_reg; // walks taken so far
  logic [1:0]         last_regime_reg;

  // apb phase decode
  logic               acc_phase;      // access phase, not yet answered
  logic               wr_commit;      // edge at which a write lands
  logic               addr_hit;       // decoded address is mapped
  logic [DATA_W-1:0]  rd_next;        // read mux output

  assign acc_phase = psel && penable && !pready;
  assign wr_commit = psel && penable && pready && pwrite && !pslverr;

  // strobed merge of one 32-bit word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // combinational read mux and address decode
  always_comb begin
    rd_next  = WORD_ZERO;
    addr_hit = 1'b1;
    case (paddr)
      OFF_EL1_CTRL_LO: rd_next = el1_ctrl_reg[31:0];
      OFF_EL1_CTRL_HI: rd_next = el1_ctrl_reg[63:32];
      OFF_EL2_CTRL_LO: rd_next = el2_ctrl_reg[31:0];
      OFF_EL2_CTRL_HI: rd_next = el2_ctrl_reg[63:32];
      OFF_EL3_CTRL:    rd_next = el3_ctrl_reg;
      // misaligned base bits read back as written
      OFF_EL1_BASE_LO: rd_next = el1_base_reg[31:0];
      OFF_EL1_BASE_HI: rd_next = el1_base_reg[63:32];
      OFF_EL2_BASE_LO: rd_next = el2_base_reg[31:0];
      OFF_EL2_BASE_HI: begin
        // address_space_id field only exists in the el1 layout
        rd_next = el2_base_reg[63:32];
        if (!host_ext_reg) begin
          rd_next[ADDRESS_SPACE_ID_MSB-32:ADDRESS_SPACE_ID_LSB-32] = '0;
        end
      end
      OFF_EL3_BASE_LO: rd_next = el3_base_reg[31:0];
      OFF_EL3_BASE_HI: begin
        // el3 address_space_id bits are reserved zero
        rd_next = el3_base_reg[63:32];
        rd_next[ADDRESS_SPACE_ID_MSB-32:ADDRESS_SPACE_ID_LSB-32] = '0;
      end
      OFF_MODE: rd_next[MODE_HOST_EXT_BIT] = host_ext_reg;
      OFF_STATUS: begin
        rd_next[STAT_REGIME_LSB +: 2]       = last_regime_reg;
        rd_next[STAT_COUNT_LSB +: COUNT_W]  = walk_count_reg;
      end
      default: addr_hit = 1'b0; // unmapped: error answer
    endcase
  end

  // apb answer: one wait state so every output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= WORD_ZERO;
      pslverr <= 1'b0;
    end else if (acc_phase) begin
      // answer comes in the second access cycle
      pready  <= 1'b1;
      prdata  <= pwrite ? WORD_ZERO : rd_next;
      pslverr <= !addr_hit;
    end else begin
      // drop the answer once the master has seen it
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // el1 control, every field writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      el1_ctrl_reg <= UNKNOWN_RESET;
    end else if (wr_commit && paddr == OFF_EL1_CTRL_LO) begin
      el1_ctrl_reg[31:0] <= merge(el1_ctrl_reg[31:0], pwdata, pstrb);
    end else if (wr_commit && paddr == OFF_EL1_CTRL_HI) begin
      // bits 52:39 kept in full, none forced reserved
      el1_ctrl_reg[63:32] <= merge(el1_ctrl_reg[63:32], pwdata, pstrb);
    end
  end

  // el2 control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      el2_ctrl_reg <= UNKNOWN_RESET;
    end else if (wr_commit && paddr == OFF_EL2_CTRL_LO) begin
      el2_ctrl_reg[31:0] <= merge(el2_ctrl_reg[31:0], pwdata, pstrb);
    end else if (wr_commit && paddr == OFF_EL2_CTRL_HI) begin
      el2_ctrl_reg[63:32] <= merge(el2_ctrl_reg[63:32], pwdata, pstrb);
    end
  end

  // el3 control, single word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      el3_ctrl_reg <= UNKNOWN_RESET[31:0];
    end else if (wr_commit && paddr == OFF_EL3_CTRL) begin
      el3_ctrl_reg <= merge(el3_ctrl_reg, pwdata, pstrb);
    end
  end

  // el1 table base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      el1_base_reg <= UNKNOWN_RESET;
    end else if (wr_commit && paddr == OFF_EL1_BASE_LO) begin
      el1_base_reg[31:0] <= merge(el1_base_reg[31:0], pwdata, pstrb);
    end else if (wr_commit && paddr == OFF_EL1_BASE_HI) begin
      el1_base_reg[63:32] <= merge(el1_base_reg[63:32], pwdata, pstrb);
    end
  end

  // el2 table base, upper bits stored for the el1 layout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      el2_base_reg <= UNKNOWN_RESET;
    end else if (wr_commit && paddr == OFF_EL2_BASE_LO) begin
      el2_base_reg[31:0] <= merge(el2_base_reg[31:0], pwdata, pstrb);
    end else if (wr_commit && paddr == OFF_EL2_BASE_HI) begin
      el2_base_reg[63:32] <= merge(el2_base_reg[63:32], pwdata, pstrb);
    end
  end

  // el3 table base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      el3_base_reg <= UNKNOWN_RESET;
    end else if (wr_commit && paddr == OFF_EL3_BASE_LO) begin
      el3_base_reg[31:0] <= merge(el3_base_reg[31:0], pwdata, pstrb);
    end else if (wr_commit && paddr == OFF_EL3_BASE_HI) begin
      el3_base_reg[63:32] <= merge(el3_base_reg[63:32], pwdata, pstrb);
    end
  end

  // host extension mode bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ext_reg <= 1'b0;
    end else if (wr_commit && paddr == OFF_MODE && pstrb[0]) begin
      host_ext_reg <= pwdata[MODE_HOST_EXT_BIT];
    end
  end

  // walk view: selected registers decoded per regime
  logic [63:0]       sel_ctrl;    // control of the chosen regime
  logic [63:0]       sel_base;    // base of the chosen regime
  logic              el1_fmt;     // decode with el1 layout
  logic              has_address_space_id;    // regime carries an address_space_id
  logic [VA_W-1:0]   align_mask;  // clears bits below x
  logic [VA_W-1:0]   base_next;
  logic              af_next;
  logic              dirty_next;
  logic              lower_next;
  logic              upper_next;

  always_comb begin
    sel_ctrl = el1_ctrl_reg;
    sel_base = el1_base_reg;
    el1_fmt  = 1'b1;
    has_address_space_id = 1'b1;
    case (regime_t'(walk_regime))
      REGIME_EL1: begin
        sel_ctrl = el1_ctrl_reg;
        sel_base = el1_base_reg;
      end
      REGIME_EL2: begin
        // host extension swaps in the el1 field layout
        sel_ctrl = el2_ctrl_reg;
        sel_base = el2_base_reg;
        el1_fmt  = host_ext_reg;
        has_address_space_id = host_ext_reg;
      end
      REGIME_EL3: begin
        sel_ctrl = {32'h0, el3_ctrl_reg};
        sel_base = el3_base_reg;
        el1_fmt  = 1'b0;
        has_address_space_id = 1'b0;
      end
      default: begin
        // unused code behaves as el1
        sel_ctrl = el1_ctrl_reg;
        sel_base = el1_base_reg;
      end
    endcase
  end

  // field decode; misaligned base bits are masked off for the walk
  always_comb begin
    // mask of all ones from bit x upward, bit 0 always clear; x of 0 or 1 keeps bits 47:1
    align_mask = {VA_W{1'b1}} << walk_align_lsb;
    align_mask[CNP_BIT] = 1'b0;
    // bits x-1 down to 1 act as zero during the walk
    base_next = sel_base[TABLE_BASE_ADDRESS_MSB:0] & align_mask;
    if (el1_fmt) begin
      lower_next = sel_ctrl[LOWER_SCOPE_BIT];
      upper_next = sel_ctrl[UPPER_SCOPE_BIT];
      af_next    = sel_ctrl[EL1_AF_BIT];
      // dirty tracking is void without access flag update
      dirty_next = sel_ctrl[EL1_DIRTY_BIT] && sel_ctrl[EL1_AF_BIT];
    end else begin
      // one scope bit covers the single range
      lower_next = sel_ctrl[TAG_SCOPE_BIT];
      upper_next = sel_ctrl[TAG_SCOPE_BIT];
      af_next    = sel_ctrl[AF_BIT];
      dirty_next = sel_ctrl[DIRTY_BIT];
    end
  end

  // snapshot at walk start, held for the walk's whole life
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      walk_table_base         <= '0;
      walk_common_not_private <= 1'b0;
      walk_address_space_id   <= '0;
      walk_address_space_id_from_lower    <= 1'b0;
      walk_lower_tag_scope    <= 1'b0;
      walk_upper_tag_scope    <= 1'b0;
      walk_access_flag_update <= 1'b0;
      walk_dirty_update       <= 1'b0;
      walk_el1_layout         <= 1'b0;
    end else if (walk_start) begin
      // later register writes cannot disturb a walk in flight
      walk_table_base         <= base_next;
      walk_common_not_private <= sel_base[CNP_BIT];
      walk_el1_layout         <= el1_fmt;
      walk_lower_tag_scope    <= lower_next;
      walk_upper_tag_scope    <= upper_next;
      walk_access_flag_update <= af_next;
      walk_dirty_update       <= dirty_next;
      // selector 0 picks this lower base's address_space_id
      walk_address_space_id_from_lower    <= has_address_space_id && !sel_ctrl[ADDRESS_SPACE_ID_SEL_BIT];
      walk_address_space_id   <= has_address_space_id ? sel_base[ADDRESS_SPACE_ID_MSB:ADDRESS_SPACE_ID_LSB] : '0;
    end
  end

  // walk bookkeeping shown in the status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      walk_count_reg  <= '0;
      last_regime_reg <= 2'h0;
    end else if (walk_start) begin
      // count wraps; it is a debug aid only
      walk_count_reg  <= walk_count_reg + COUNT_W'(1);
      last_regime_reg <= walk_regime;
    end
  end

endmodule // xlat_regs

// ==== common/xlat_regs_pkg.sv ====
/*
  constants for the stage 1 translation control and table base bank:
  apb word offsets, field positions, reset values and walk regimes.
  assumes 32-bit apb data with each 64-bit register split in two words.
*/
package xlat_regs_pkg;

  // apb geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;

  // byte offsets, low word then high word for 64-bit registers
  localparam logic [ADDR_W-1:0] OFF_EL1_CTRL_LO = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EL1_CTRL_HI = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EL2_CTRL_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EL2_CTRL_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_EL3_CTRL    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EL1_BASE_LO = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EL1_BASE_HI = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_EL2_BASE_LO = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_EL2_BASE_HI = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_EL3_BASE_LO = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_EL3_BASE_HI = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_MODE        = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'h30;

  // el1 control layout (also el2 under host extension)
  localparam int unsigned LOWER_SCOPE_BIT = 52;
  localparam int unsigned UPPER_SCOPE_BIT = 51;
  localparam int unsigned EL1_DIRTY_BIT   = 40;
  localparam int unsigned EL1_AF_BIT      = 39;
  localparam int unsigned ADDRESS_SPACE_ID_SEL_BIT    = 22;

  // el2 / el3 control layout
  localparam int unsigned TAG_SCOPE_BIT = 29;
  localparam int unsigned DIRTY_BIT     = 22;
  localparam int unsigned AF_BIT        = 21;

  // table base layout
  localparam int unsigned ADDRESS_SPACE_ID_MSB  = 63;
  localparam int unsigned ADDRESS_SPACE_ID_LSB  = 48;
  localparam int unsigned TABLE_BASE_ADDRESS_MSB = 47;
  localparam int unsigned TABLE_BASE_ADDRESS_LSB = 1;
  localparam int unsigned CNP_BIT   = 0;
  localparam int unsigned ADDRESS_SPACE_ID_W    = ADDRESS_SPACE_ID_MSB - ADDRESS_SPACE_ID_LSB + 1;
  localparam int unsigned VA_W      = TABLE_BASE_ADDRESS_MSB + 1;

  // mode register field
  localparam int unsigned MODE_HOST_EXT_BIT = 0;

  // status register fields
  localparam int unsigned STAT_REGIME_LSB = 0;
  localparam int unsigned STAT_COUNT_LSB  = 16;
  localparam int unsigned COUNT_W         = 16;

  // architecturally unknown fields come up as this value
  localparam logic [63:0] UNKNOWN_RESET = 64'h0;
  localparam logic [31:0] WORD_ZERO     = 32'h0;

  // translation regime of a walk
  typedef enum logic [1:0] {
    REGIME_EL1,
    REGIME_EL2,
    REGIME_EL3
  } regime_t;

endpackage

// ==== test/xlat_regs_assertions.sv ====
/*
  port-level assertions for the translation register bank.
  assumes one clock, presetn async active low, walker pulses walk_start.
*/
`timescale 1ns/1ps
module xlat_regs_checker
  import xlat_regs_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [STRB_W-1:0] pstrb,
  input wire logic              pready,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pslverr,
  input wire logic              walk_start,
  input wire logic [1:0]        walk_regime,
  input wire logic [5:0]        walk_align_lsb,
  input wire logic [VA_W-1:0]   walk_table_base,
  input wire logic              walk_common_not_private,
  input wire logic [ADDRESS_SPACE_ID_W-1:0] walk_address_space_id,
  input wire logic              walk_address_space_id_from_lower,
  input wire logic              walk_lower_tag_scope,
  input wire logic              walk_upper_tag_scope,
  input wire logic              walk_access_flag_update,
  input wire logic              walk_dirty_update,
  input wire logic              walk_el1_layout
);
  // everything here lives on pclk and is muted in reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not a single cycle");
  chk_dirty_needs_af: assert property (walk_el1_layout && walk_dirty_update |-> walk_access_flag_update)
    else $error("dirty update without access flag update");
  chk_el1_layout: assert property (walk_start && walk_regime == 2'h0 |=> walk_el1_layout)
    else $error("el1 walk without el1 layout");
  chk_el3_no_address_space_id: assert property (walk_start && walk_regime == 2'h2 |=>
    !walk_el1_layout && walk_address_space_id == '0 && !walk_address_space_id_from_lower)
    else $error("el3 walk carries an address_space_id");
  chk_single_scope: assert property (walk_start && walk_regime == 2'h2 |=>
    walk_lower_tag_scope == walk_upper_tag_scope)
    else $error("el3 scopes differ");
  chk_base_bit0: assert property (walk_start |=> !walk_table_base[0])
    else $error("walk base bit 0 not cleared");
  chk_base_wide_x: assert property (walk_start && walk_align_lsb >= 6'h30 |=> walk_table_base == '0)
    else $error("walk base not cleared for wide x");
  // walk base, address_space_id and dirty update must not move between walks
  chk_walk_hold: assert property (!walk_start |=>
    $stable(walk_table_base) && $stable(walk_address_space_id) && $stable(walk_dirty_update))
    else $error("walk outputs changed without a walk");
  chk_reset_clear: assert property ($rose(presetn) |-> walk_table_base == '0 && !pready)
    else $error("outputs not cleared after reset");
endmodule // xlat_regs_checker

bind xlat_regs xlat_regs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .walk_start(walk_start), .walk_regime(walk_regime), .walk_align_lsb(walk_align_lsb),
  .walk_table_base(walk_table_base), .walk_common_not_private(walk_common_not_private),
  .walk_address_space_id(walk_address_space_id), .walk_address_space_id_from_lower(walk_address_space_id_from_lower),
  .walk_lower_tag_scope(walk_lower_tag_scope), .walk_upper_tag_scope(walk_upper_tag_scope),
  .walk_access_flag_update(walk_access_flag_update), .walk_dirty_update(walk_dirty_update),
  .walk_el1_layout(walk_el1_layout));

// ==== test/xlat_regs_test.sv ====
/*
  self-checking bench for the translation register bank.
  assumes the apb slave answers by itself; walks are driven here.
*/
`timescale 1ns/1ps
module xlat_regs_test
  import xlat_regs_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err, walk_start;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [STRB_W-1:0] pstrb;
  logic [1:0]        walk_regime;
  logic [5:0]        walk_align_lsb;
  logic [VA_W-1:0]   walk_table_base;
  logic [ADDRESS_SPACE_ID_W-1:0] walk_address_space_id;
  logic              walk_common_not_private, walk_address_space_id_from_lower, walk_lower_tag_scope;
  logic              walk_upper_tag_scope, walk_access_flag_update, walk_dirty_update, walk_el1_layout;
  logic [6:0]        walk_flags;
  int                fails, samples_checked;
  logic [7:0]        offs [13] = '{OFF_EL1_CTRL_LO, OFF_EL1_CTRL_HI, OFF_EL2_CTRL_LO, OFF_EL2_CTRL_HI,
    OFF_EL3_CTRL, OFF_EL1_BASE_LO, OFF_EL1_BASE_HI, OFF_EL2_BASE_LO, OFF_EL2_BASE_HI, OFF_EL3_BASE_LO,
    OFF_EL3_BASE_HI, OFF_MODE, OFF_STATUS};

  // flags packed so one compare covers them
  assign walk_flags = {walk_el1_layout, walk_dirty_update, walk_access_flag_update, walk_upper_tag_scope,
                       walk_lower_tag_scope, walk_address_space_id_from_lower, walk_common_not_private};

  xlat_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .walk_start(walk_start), .walk_regime(walk_regime), .walk_align_lsb(walk_align_lsb),
    .walk_table_base(walk_table_base), .walk_common_not_private(walk_common_not_private),
    .walk_address_space_id(walk_address_space_id), .walk_address_space_id_from_lower(walk_address_space_id_from_lower),
    .walk_lower_tag_scope(walk_lower_tag_scope), .walk_upper_tag_scope(walk_upper_tag_scope),
    .walk_access_flag_update(walk_access_flag_update), .walk_dirty_update(walk_dirty_update),
    .walk_el1_layout(walk_el1_layout));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // case compare so unknowns never match
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; waits for pready, idle cycle after to avoid double drives
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request held until ready is seen; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    apb(1'b0, a, 32'h0);
    cmp("prdata", exp, rd);
    cmp("pslverr", eexp, err);
  endtask

  // one-cycle walk pulse, results visible one edge later
  task automatic walk(input logic [1:0] r, input logic [5:0] x, input logic [6:0] f,
                      input logic [47:0] b, input logic [15:0] id);
    walk_start <= 1'b1;
    walk_regime <= r;
    walk_align_lsb <= x;
    @(posedge pclk);
    walk_start <= 1'b0;
    @(posedge pclk);
    cmp("walk_flags", f, walk_flags);
    cmp("walk_table_base", b, walk_table_base);
    cmp("walk_address_space_id", id, walk_address_space_id);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog well past the fewer than 200 cycles the run needs
  initial begin
    #20000;
    fails++;
    end_of_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, walk_start} = 5'h0;
    {paddr, pwdata, walk_regime, walk_align_lsb} = '0;
    pstrb = 4'hf;
    fails = 0;
    samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) rdc(offs[i], WORD_ZERO, 1'b0);
    apb(1'b1, OFF_EL1_CTRL_HI, 32'h0018_0180);
    rdc(OFF_EL1_CTRL_HI, 32'h0018_0180, 1'b0);
    apb(1'b1, OFF_EL1_BASE_LO, 32'h5678_9abd);
    apb(1'b1, OFF_EL1_BASE_HI, 32'habcd_1234);
    rdc(OFF_EL1_BASE_LO, 32'h5678_9abd, 1'b0);
    rdc(OFF_EL1_BASE_HI, 32'habcd_1234, 1'b0);
    walk(2'h0, 6'h0c, 7'h7f, 48'h1234_5678_9000, 16'habcd);
    // dirty set without access flag must not enable dirty update
    apb(1'b1, OFF_EL1_CTRL_HI, 32'h0000_0100);
    walk(2'h0, 6'h0c, 7'h43, 48'h1234_5678_9000, 16'habcd);
    apb(1'b1, OFF_EL2_CTRL_LO, 32'h2060_0000);
    apb(1'b1, OFF_EL2_BASE_LO, 32'h0000_0fff);
    apb(1'b1, OFF_EL2_BASE_HI, 32'h5a5a_0001);
    rdc(OFF_EL2_BASE_HI, 32'h0000_0001, 1'b0);
    walk(2'h1, 6'h0c, 7'h3d, 48'h0001_0000_0000, 16'h0);
    apb(1'b1, OFF_EL3_CTRL, 32'h0040_0000);
    rdc(OFF_EL3_CTRL, 32'h0040_0000, 1'b0);
    walk(2'h2, 6'h30, 7'h20, 48'h0, 16'h0);
    apb(1'b1, OFF_EL3_BASE_HI, 32'hffff_0000);
    rdc(OFF_EL3_BASE_HI, WORD_ZERO, 1'b0);
    // host extension switches el2 to the el1 layout
    apb(1'b1, OFF_MODE, 32'h0000_0001);
    apb(1'b1, OFF_EL2_CTRL_HI, 32'h0010_0080);
    rdc(OFF_EL2_BASE_HI, 32'h5a5a_0001, 1'b0);
    walk(2'h1, 6'h04, 7'h55, 48'h0001_0000_0ff0, 16'h5a5a);
    apb(1'b1, OFF_STATUS, 32'hffff_ffff);
    rdc(OFF_STATUS, 32'h0005_0001, 1'b0);
    // new base written with no walk: the last snapshot must stand
    apb(1'b1, OFF_EL2_BASE_LO, 32'h0000_0000);
    cmp("walk_table_base", 48'h0001_0000_0ff0, walk_table_base);
    // software keeps this table aligned to the walker's x
    walk(2'h1, 6'h0c, 7'h54, 48'h0001_0000_0000, 16'h5a5a);
    apb(1'b1, 8'h40, 32'h1234_5678);
    cmp("pslverr", 1'b1, err);
    end_of_test();
  end
endmodule // xlat_regs_test
